// File: rtl/card_mode_pkg.sv
// How it works
// R1: card runs memory, I/O or disk-drive personality, exactly one at once.
// R2: mode-select low gives disk mode; else config register picks card personality.
// R3: card-mode configuration register sits in attribute space at byte 200h.
// R4: configuration tuple in the info structure reports the 200h register base.
// R5: a 256-byte card info structure in attribute memory is host readable.
// R6: after each command completes the card drops into low power by itself.
// R7: a new command in low power wakes the card and is processed.
// R8: non-data outputs always driven; data bus released unless read data supplied.
// R9: upper data byte used only for 16-bit access; floating upper lines ignored.
// R10: mode-select sampled once after reset; personality fixed until next reset. Code fixes only disk vs card; config still switches memory/I/O.
package card_mode_pkg;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MODE_MEMORY, MODE_IO, MODE_DISK} if_mode_t;
  typedef enum logic {PWR_ACTIVE, PWR_SLEEP} pwr_state_t;

  // host side strobes, address and incoming data, all active-low strobes
  typedef struct packed {
    logic        low_byte_card_enable_n;
    logic        high_byte_card_enable_n;
    logic        attr_select_n;
    logic        mem_read_n;
    logic        mem_write_n;
    logic        io_read_n;
    logic        io_write_n;
    logic [10:0] addr;
    logic [15:0] data;
  } host_bus_t;

  // ---------------------------------------------------------------
  // layout constants
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 11;
  localparam int          DATA_W        = 16;
  localparam int          CIS_BYTES     = 256;
  localparam int          CIS_IDX_W     = 8;
  localparam logic [10:0] CFG_BASE      = 11'h200;
  localparam int          CFG_SRST_BIT  = 7;
  localparam int          CFG_INDEX_W   = 6;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  // card info structure contents
  localparam logic [7:0]  TUPLE_CONFIG  = 8'h1a;
  localparam logic [7:0]  TUPLE_LINK    = 8'h05;
  localparam logic [7:0]  TUPLE_SIZES   = 8'h01;
  localparam logic [7:0]  TUPLE_LAST    = 8'h03;
  localparam logic [7:0]  TUPLE_MASK    = 8'h01;
  localparam logic [7:0]  TUPLE_END     = 8'hff;
  localparam logic [7:0]  CIS_BLANK     = 8'hff;
  localparam logic [7:0]  IDX_CODE      = 8'h00;
  localparam logic [7:0]  IDX_LINK      = 8'h01;
  localparam logic [7:0]  IDX_SIZES     = 8'h02;
  localparam logic [7:0]  IDX_LAST      = 8'h03;
  localparam logic [7:0]  IDX_BASE_LO   = 8'h04;
  localparam logic [7:0]  IDX_BASE_HI   = 8'h05;
  localparam logic [7:0]  IDX_MASK      = 8'h06;
  localparam logic [7:0]  IDX_END       = 8'h07;

endpackage : card_mode_pkg

// File: rtl/cis_rom.sv
`timescale 1ns/1ps
`default_nettype none
module cis_rom
  import card_mode_pkg::*;
(
  input  wire logic [7:0] i_index,
  output logic      [7:0] o_byte
);

  // ---------------------------------------------------------------
  // fixed info structure, config tuple carries the register base
  // ---------------------------------------------------------------
  function automatic logic [7:0] cis_byte(input logic [7:0] idx);
    logic [7:0] b;
    b = CIS_BLANK;
    unique case (idx)
      IDX_CODE:    b = TUPLE_CONFIG;
      IDX_LINK:    b = TUPLE_LINK;
      IDX_SIZES:   b = TUPLE_SIZES;
      IDX_LAST:    b = TUPLE_LAST;
      IDX_BASE_LO: b = CFG_BASE[7:0];                 // [R4]
      IDX_BASE_HI: b = {5'h00, CFG_BASE[10:8]};       // [R4]
      IDX_MASK:    b = TUPLE_MASK;
      IDX_END:     b = TUPLE_END;
      default:     b = CIS_BLANK;
    endcase
    return b;
  endfunction : cis_byte

  assign o_byte = cis_byte(i_index);

endmodule : cis_rom
`default_nettype wire

// File: rtl/card_mode_select_power.sv
`timescale 1ns/1ps
`default_nettype none
module card_mode_select_power
  import card_mode_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_DISK_MODE_SELECT_N,
  input  wire host_bus_t         I_HOST,
  input  wire logic [15:0]       I_TASK_DATA,
  input  wire logic              I_CMD_START,
  input  wire logic              I_CMD_DONE,
  output logic      [15:0]       O_DATA,
  output logic      [15:0]       O_DATA_OE,
  output var if_mode_t           O_MODE,
  output logic      [7:0]        O_CONFIG,
  output logic                   O_LOW_POWER,
  output logic                   O_WAKE
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // attribute byte index for the info structure, even addresses only
  function automatic logic cis_hit(input logic [10:0] a);
    return (a[10:9] == 2'h0) && !a[0];
  endfunction : cis_hit

  function automatic logic cfg_hit(input logic [10:0] a);
    return a == CFG_BASE;
  endfunction : cfg_hit

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       sampled;
  logic       disk;
  logic [7:0] cfg;
  if_mode_t   mode;
  if_mode_t   next_mode;
  pwr_state_t pwr;
  logic [7:0] cis_data;
  logic       card_mode;
  logic       attr_rd;
  logic       attr_wr;
  logic       task_rd;
  logic       rd_any;
  logic       wide;
  logic [7:0] attr_byte;

  cis_rom u_cis (
    .i_index (I_HOST.addr[8:1]),
    .o_byte  (cis_data)
  );

  // ---------------------------------------------------------------
  // personality select
  // ---------------------------------------------------------------
  // mode-select caught once in the first cycle after reset release
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      sampled <= 1'b0;
      disk    <= 1'b0;
    end
    else if (!sampled)
    begin
      sampled <= 1'b1;
      disk    <= !I_DISK_MODE_SELECT_N;     // [R2] [R10]
    end
  end

  // exactly one personality, disk strap wins over config
  always_comb
  begin
    if (disk)
      next_mode = MODE_DISK;                // [R2]
    else if (cfg[CFG_INDEX_W-1:0] != 6'h00)
      next_mode = MODE_IO;                  // [R1]
    else
      next_mode = MODE_MEMORY;              // [R1]
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      mode <= MODE_MEMORY;
    else
      mode <= next_mode;
  end

  // ---------------------------------------------------------------
  // host access decode
  // ---------------------------------------------------------------
  assign card_mode = sampled && !disk;
  assign wide      = !I_HOST.high_byte_card_enable_n;
  assign attr_rd   = card_mode && !I_HOST.low_byte_card_enable_n
                     && !I_HOST.attr_select_n && !I_HOST.mem_read_n;
  assign attr_wr   = card_mode && !I_HOST.low_byte_card_enable_n
                     && !I_HOST.attr_select_n && !I_HOST.mem_write_n;
  // task-file reads per personality
  assign task_rd   = !I_HOST.low_byte_card_enable_n && (
                     (disk && !I_HOST.io_read_n) ||
                     (card_mode && mode == MODE_MEMORY
                      && I_HOST.attr_select_n && !I_HOST.mem_read_n) ||
                     (card_mode && mode == MODE_IO && !I_HOST.io_read_n));
  assign rd_any    = attr_rd || task_rd;

  // attribute read byte: info structure or configuration register
  always_comb
  begin
    if (cfg_hit(I_HOST.addr))
      attr_byte = cfg;                      // [R3]
    else if (cis_hit(I_HOST.addr))
      attr_byte = cis_data;                 // [R5]
    else
      attr_byte = BYTE_ZERO;
  end

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // only the low byte is taken, floating upper lines never reach it
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      cfg <= CFG_RESET;
    else if (attr_wr && cfg_hit(I_HOST.addr))
    begin
      if (I_HOST.data[CFG_SRST_BIT])
        cfg <= CFG_RESET;                   // soft reset clears index
      else
        cfg <= I_HOST.data[7:0];            // [R3] [R9]
    end
  end

  // ---------------------------------------------------------------
  // data bus drive
  // ---------------------------------------------------------------
  // released whenever no read data is supplied
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_DATA    <= 16'h0000;
      O_DATA_OE <= 16'h0000;
    end
    else
    begin
      O_DATA_OE[7:0]  <= {8{rd_any}};                   // [R8]
      O_DATA_OE[15:8] <= {8{task_rd && wide}};          // [R8] [R9]
      if (attr_rd)
        O_DATA <= {8'h00, attr_byte};
      else if (task_rd)
        O_DATA <= wide ? I_TASK_DATA : {8'h00, I_TASK_DATA[7:0]};
      else
        O_DATA <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // automatic power management
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      pwr <= PWR_ACTIVE;
    else
    begin
      unique case (pwr)
        PWR_ACTIVE:
          if (I_CMD_DONE && !I_CMD_START)
            pwr <= PWR_SLEEP;               // [R6]
        PWR_SLEEP:
          if (I_CMD_START)
            pwr <= PWR_ACTIVE;              // [R7]
      endcase
    end
  end

  // one-cycle wake marker
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      O_WAKE <= 1'b0;
    else
      O_WAKE <= (pwr == PWR_SLEEP) && I_CMD_START;   // [R7]
  end

  // non-data outputs driven at all times
  assign O_MODE      = mode;                // [R8]
  assign O_CONFIG    = cfg;
  assign O_LOW_POWER = (pwr == PWR_SLEEP);  // [R8]

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  AST_ONE_MODE: assert property (mode inside {MODE_MEMORY, MODE_IO, MODE_DISK} // [R1]
    && (mode != MODE_DISK || disk))
    else $error("mode code illegal");
  AST_DISK_SEL: assert property (sampled && disk |=> mode == MODE_DISK) // [R2]
    else $error("disk strap not honoured");
  AST_IO_SEL: assert property (card_mode && cfg[5:0] != 6'h00 |=> mode == MODE_IO) // [R1]
    else $error("config index did not select io mode");
  AST_CFG_READ: assert property (attr_rd && cfg_hit(I_HOST.addr) // [R3]
    |=> O_DATA[7:0] == $past(cfg) && O_DATA_OE[0])
    else $error("config register not at base");
  AST_CIS_BASE: assert property (attr_rd && I_HOST.addr == 11'h00a // [R4]
    |=> O_DATA[7:0] == {5'h00, CFG_BASE[10:8]})
    else $error("tuple base high byte wrong");
  AST_CIS_CODE: assert property (attr_rd && I_HOST.addr == 11'h000 // [R5]
    |=> O_DATA[7:0] == TUPLE_CONFIG)
    else $error("info structure first byte wrong");
  AST_SLEEP: assert property (!O_LOW_POWER && I_CMD_DONE && !I_CMD_START // [R6]
    |=> O_LOW_POWER)
    else $error("no low power after command");
  AST_WAKE: assert property (O_LOW_POWER && I_CMD_START // [R7]
    |=> !O_LOW_POWER && O_WAKE ##1 !O_WAKE)
    else $error("command did not wake card");
  AST_BUS_RELEASE: assert property (!rd_any |=> O_DATA_OE == 16'h0000) // [R8]
    else $error("data bus driven without read");
  AST_HIGH_BYTE: assert property (O_DATA_OE[15:8] != 8'h00 |-> $past(wide)) // [R9]
    else $error("upper byte driven on narrow access");
  AST_STRAP_HOLD: assert property (sampled |=> sampled && $stable(disk)) // [R10]
    else $error("personality changed without reset");

  COV_DISK_READ: cover property (disk && task_rd ##1 O_DATA_OE[0]);
  COV_IO_SWITCH: cover property (mode == MODE_MEMORY ##1 mode == MODE_IO);
  COV_SLEEP_WAKE: cover property (O_LOW_POWER ##1 O_WAKE);
  COV_CIS_READ: cover property (attr_rd && cis_hit(I_HOST.addr));

endmodule : card_mode_select_power
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import card_mode_pkg::*;
(
  input  wire logic      i_clk,
  output var  host_bus_t o_host
);
  // ---------------------------------------------------------------
  // host bus driver
  // ---------------------------------------------------------------
  // all strobes released at time zero
  initial o_host = {7'h7f, 11'h000, 16'h0000};

  // upper byte left floating by an 8-bit host: changes every cycle
  always @(posedge i_clk)
    o_host.data[15:8] <= o_host.data[15:8] ^ 8'h5a;

  // one bus cycle: drive after the edge, held until the next edge
  task automatic bus(input logic [6:0] s, input logic [10:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_host[33:16]    <= {s, a};
    o_host.data[7:0] <= d;
  endtask : bus
endmodule : host_model
`default_nettype wire

// File: test/card_mode_select_power_tb.sv
`timescale 1ns/1ps
`default_nettype none
module card_mode_select_power_tb;
  import card_mode_pkg::*;
  // strobes: ce_lo, ce_hi, attr, mrd, mwr, iord, iowr
  localparam logic [6:0] IDLE = 7'h7f;
  localparam logic [6:0] A_RD = 7'h27;
  localparam logic [6:0] A_WR = 7'h2b;
  localparam logic [6:0] M_16 = 7'h17;
  localparam logic [6:0] M_8  = 7'h37;
  localparam logic [6:0] IO16 = 7'h1d;
  logic        I_CLK = 1'b0;
  logic        I_RST = 1'b1;
  logic        strap = 1'b1;
  logic [15:0] task_data = 16'h0000;
  logic        cmd_start = 1'b0;
  logic        cmd_done = 1'b0;
  host_bus_t   host;
  logic [15:0] O_DATA, O_DATA_OE;
  if_mode_t    O_MODE;
  logic [7:0]  O_CONFIG;
  logic        O_LOW_POWER, O_WAKE;
  logic [31:0] exp_q[$];
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  always #2 I_CLK = ~I_CLK;

  host_model i_host (.i_clk(I_CLK), .o_host(host));
  card_mode_select_power i_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_DISK_MODE_SELECT_N(strap),
    .I_HOST(host), .I_TASK_DATA(task_data), .I_CMD_START(cmd_start), .I_CMD_DONE(cmd_done),
    .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .O_MODE(O_MODE), .O_CONFIG(O_CONFIG),
    .O_LOW_POWER(O_LOW_POWER), .O_WAKE(O_WAKE));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_total++;
      $display("mismatch at %0t got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  function automatic logic [7:0] cis_byte(input int n);
    case (n)
      0: return TUPLE_CONFIG;
      1: return TUPLE_LINK;
      2: return TUPLE_SIZES;
      3: return TUPLE_LAST;
      4: return 8'h00; // register base 200h, low
      5: return 8'h02; // register base 200h, high
      6: return TUPLE_MASK;
      default: return 8'hff;
    endcase
  endfunction : cis_byte

  // attribute read, expectation noted in the queue
  task automatic rd(input logic [10:0] a, input logic [7:0] b);
    i_host.bus(A_RD, a, 8'h00);
    exp_q.push_back({16'h00ff, 8'h00, b});
  endtask : rd

  // task-file read with fresh random data
  task automatic rdt(input logic [6:0] s, input logic [15:0] oe);
    logic [15:0] v;
    v = 16'($urandom);
    i_host.bus(s, 11'h000, 8'h00);
    task_data <= v;
    exp_q.push_back({oe, v & oe});
  endtask : rdt

  task automatic mode_is(input if_mode_t m);
    i_host.bus(IDLE, 11'h000, 8'h00);
    @(posedge I_CLK);
    #1 check({30'h0, O_MODE}, {30'h0, m});
  endtask : mode_is

  // command pulses, power state checked after the sampling edge
  task automatic pwr(input logic s, input logic d, input logic lp, input logic wk);
    @(posedge I_CLK);
    cmd_start <= s;
    cmd_done <= d;
    @(posedge I_CLK);
    cmd_start <= 1'b0;
    cmd_done <= 1'b0;
    #1 check({O_LOW_POWER, O_WAKE}, {lp, wk});
  endtask : pwr

  // strap flips after capture to show it is not followed
  task automatic do_reset(input logic v);
    strap <= v;
    I_RST <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    strap <= ~v;
  endtask : do_reset

  // ---------------------------------------------------------------
  // result monitor and watchdog
  // ---------------------------------------------------------------
  // any drive of the data bus must match the oldest note
  always @(posedge I_CLK)
    if (O_DATA_OE !== 16'h0000)
    begin
      if (exp_q.size() == 0)
        check({O_DATA_OE, O_DATA}, 32'h0);
      else
        check({O_DATA_OE, O_DATA}, exp_q.pop_front());
    end

  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(70915));
    do_reset(1'b1);
    #1 check({O_DATA_OE, O_CONFIG, 6'h0, O_LOW_POWER, O_WAKE}, 32'h0);
    mode_is(MODE_MEMORY);
    for (int n = 0; n < 9; n++)
      rd(11'(2 * n), cis_byte(n));
    rd(11'h1fe, 8'hff);
    rd(11'h003, 8'h00);
    rd(CFG_BASE, 8'h00);
    i_host.bus(A_WR, CFG_BASE, 8'h01);
    mode_is(MODE_IO);
    rd(CFG_BASE, 8'h01);
    rdt(IO16, 16'hffff);
    i_host.bus(A_WR, 11'h202, 8'h00);
    mode_is(MODE_IO);
    i_host.bus(A_WR, CFG_BASE, 8'h81);
    mode_is(MODE_MEMORY);
    check({24'h0, O_CONFIG}, 32'h0);
    rdt(M_16, 16'hffff);
    rdt(M_8, 16'h00ff);
    i_host.bus(IDLE, 11'h000, 8'h00);
    pwr(1'b0, 1'b1, 1'b1, 1'b0);
    pwr(1'b0, 1'b1, 1'b1, 1'b0);
    pwr(1'b1, 1'b0, 1'b0, 1'b1);
    pwr(1'b1, 1'b0, 1'b0, 1'b0);
    pwr(1'b1, 1'b1, 1'b0, 1'b0);
    do_reset(1'b0);
    #1 check({O_DATA_OE, O_CONFIG, 6'h0, O_LOW_POWER, O_WAKE}, 32'h0);
    mode_is(MODE_DISK);
    i_host.bus(A_RD, 11'h000, 8'h00);
    rdt(IO16, 16'hffff);
    i_host.bus(A_WR, CFG_BASE, 8'h01);
    mode_is(MODE_DISK);
    repeat (3) @(posedge I_CLK);
    check(32'(exp_q.size()), 32'h0);
    end_sim();
  end
endmodule : card_mode_select_power_tb
`default_nettype wire
